// ### verilog/flash_self_prog.sv
// Flash self-programming control, addressing and timing with an APB slave.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module flash_self_prog
#(
  parameter int write_ticks = flash_self_prog_pkg::write_nom_ticks
)
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    rc_tick,
  input  wire logic [1:0]              boot_size_fuse,
  input  wire logic                    eeprom_write_active,
  input  wire logic                    fetch_req,
  input  wire logic [12:0]             fetch_addr,
  output logic                         fetch_block,
  output logic                         flash_busy,
  output logic                         flash_erase_pulse,
  output logic                         flash_write_pulse,
  output logic      [6:0]              page_select_field,
  output logic      [5:0]              word_select_field,
  output logic                         byte_select,
  output logic                         irq
);
  import flash_self_prog_pkg::*;

  typedef enum logic [1:0] {st_idle, st_armed, st_prog} state_t;

  typedef struct packed {
    state_t      state;
    logic [7:0]  ctrl;
    logic [15:0] zptr;
    logic [2:0]  arm_cnt;
    logic [15:0] tick_cnt;
    op_t         op;
    logic        rww_busy;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fetch_block;
    logic        busy;
    logic        erase_p;
    logic        write_p;
    logic [6:0]  page;
    logic [5:0]  word;
    logic        byte_hi;
    logic        irq;
  } regs_t;

  regs_t r_ff;
  regs_t nxt_r;

  // Boot layout from the two fuse bits; smaller codes mean larger sections.
  function automatic boot_layout_t boot_layout(input logic [1:0] fuse);
    boot_layout_t l;
    unique case (fuse)
      2'h3: l.boot_start = 13'h1F80;
      2'h2: l.boot_start = 13'h1F00;
      2'h1: l.boot_start = 13'h1E00;
      2'h0: l.boot_start = 13'h1C00;
    endcase
    l.app_end = l.boot_start - 13'h0001;
    return l;
  endfunction

  // Z pointer split; the top two bits never reach any field.
  function automatic zdecode_t zsplit(input logic [15:0] z);
    zdecode_t d;
    d.page    = z[13:7];
    d.word    = z[6:1];
    d.byte_hi = z[0];
    return d;
  endfunction

  // READ_WHILE_WRITE_SECTION membership of a 13 bit word address.
  function automatic logic in_rww(input logic [pc_width-1:0] a);
    return a < no_read_while_write_section_start;
  endfunction

  logic        setup_ok;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  zdecode_t    zd;
  boot_layout_t lay;

  assign setup_ok = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && r_ff.pready;
  assign rd_acc   = setup_ok && !pwrite;
  assign zd       = zsplit(r_ff.zptr);
  assign lay      = boot_layout(boot_size_fuse);
  assign mapped   = paddr == ctrl_offset || paddr == zptr_offset ||
                    paddr == spm_offset || paddr == status_offset ||
                    paddr == mask_offset || paddr == layout_offset;

  // Next state: bus slave, command sequencer, timer and interrupt flags.
  always_comb
  begin
    logic [2:0] ev;
    logic [7:0] wctrl;
    ev    = 3'h0;
    wctrl = pwdata[7:0];
    nxt_r = r_ff;
    nxt_r.erase_p = 1'b0;
    nxt_r.write_p = 1'b0;
    // No wait state: pready rises in the first access cycle after setup.
    nxt_r.pready  = setup_ok;
    nxt_r.pslverr = setup_ok && !mapped;

    unique case (r_ff.state)
      st_idle:
      begin
        nxt_r.arm_cnt = 3'h0;
      end
      st_armed:
      begin
        nxt_r.arm_cnt = r_ff.arm_cnt + 3'h1;
        if (r_ff.arm_cnt == arm_window - 3'h1)
        begin
          nxt_r.ctrl  = ctrl_reset;
          nxt_r.state = st_idle;
          ev[irq_expire_pos] = 1'b1;
        end
      end
      st_prog:
      begin
        if (rc_tick)
          nxt_r.tick_cnt = r_ff.tick_cnt + 16'h0001;
        if (r_ff.tick_cnt == write_ticks[15:0])
        begin
          nxt_r.state = st_idle;
          nxt_r.busy  = 1'b0;
          nxt_r.ctrl[command_enable_pos] = 1'b0;
          nxt_r.ctrl[page_erase_pos]     = 1'b0;
          nxt_r.ctrl[page_write_pos]     = 1'b0;
          nxt_r.ctrl[lock_write_pos]     = 1'b0;
          ev[irq_done_pos] = 1'b1;
        end
      end
    endcase

    if (wr_acc)
    begin
      unique case (paddr)
        ctrl_offset:
        begin
          // Refused while busy or while the EEPROM is writing.
          if (r_ff.state == st_prog || eeprom_write_active)
            ev[irq_block_pos] = 1'b1;
          else if (wctrl[command_enable_pos])
          begin
            nxt_r.ctrl    = {1'b0, r_ff.rww_busy, 1'b0, wctrl[4:0]};
            nxt_r.state   = st_armed;
            nxt_r.arm_cnt = 3'h0;
          end
        end
        zptr_offset:   nxt_r.zptr = pwdata[15:0];
        spm_offset:
        begin
          // Store instruction strobe; acts only inside the arm window.
          if (r_ff.state == st_armed)
          begin
            nxt_r.page = zd.page;
            nxt_r.word = zd.word;
            nxt_r.byte_hi = zd.byte_hi;
            if (r_ff.ctrl[rww_reenable_pos])
            begin
              nxt_r.rww_busy = 1'b0;
              nxt_r.ctrl = ctrl_reset;
              nxt_r.state = st_idle;
              ev[irq_done_pos] = 1'b1;
            end
            else if (r_ff.ctrl[page_erase_pos] ||
                     r_ff.ctrl[page_write_pos] ||
                     r_ff.ctrl[lock_write_pos])
            begin
              nxt_r.state    = st_prog;
              nxt_r.tick_cnt = 16'h0000;
              nxt_r.busy     = 1'b1;
              nxt_r.op = r_ff.ctrl[page_erase_pos] ? op_erase :
                         r_ff.ctrl[page_write_pos] ? op_write : op_lock;
              nxt_r.erase_p  = r_ff.ctrl[page_erase_pos];
              nxt_r.write_p  = !r_ff.ctrl[page_erase_pos] &&
                               r_ff.ctrl[page_write_pos];
              // Lock writes leave the whole flash readable.
              if (!r_ff.ctrl[lock_write_pos] ||
                  r_ff.ctrl[page_erase_pos] || r_ff.ctrl[page_write_pos])
                nxt_r.rww_busy = 1'b1;
            end
            else
            begin
              // Buffer fill: the word index comes from Z bits 6..1.
              nxt_r.ctrl  = ctrl_reset;
              nxt_r.state = st_idle;
              ev[irq_done_pos] = 1'b1;
            end
          end
        end
        status_offset: nxt_r.status = r_ff.status & ~pwdata[2:0];
        mask_offset:   nxt_r.mask   = pwdata[2:0];
        default:       nxt_r.zptr   = r_ff.zptr;
      endcase
    end
    nxt_r.ctrl[rww_busy_pos] = nxt_r.rww_busy;

    // Set wins over a same-cycle write-one clear.
    nxt_r.status = nxt_r.status | ev;

    if (rd_acc)
    begin
      unique case (paddr)
        ctrl_offset:   nxt_r.prdata = {24'h0, r_ff.ctrl};
        zptr_offset:   nxt_r.prdata = {16'h0, r_ff.zptr};
        status_offset: nxt_r.prdata = {29'h0, r_ff.status};
        mask_offset:   nxt_r.prdata = {29'h0, r_ff.mask};
        layout_offset: nxt_r.prdata = {3'h0, lay.app_end,
                                       3'h0, lay.boot_start};
        default:       nxt_r.prdata = 32'h0000_0000;
      endcase
    end

    // Reads of the READ_WHILE_WRITE_SECTION section are stalled while it is busy.
    nxt_r.fetch_block = fetch_req && r_ff.rww_busy &&
                        in_rww(fetch_addr);
    nxt_r.irq = |(nxt_r.status & r_ff.mask);
  end

  // Single state register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_ff         <= '0;
      r_ff.state   <= st_idle;
      r_ff.op      <= op_none;
      r_ff.ctrl    <= ctrl_reset;
      r_ff.mask    <= mask_reset;
    end
    else
      r_ff <= nxt_r;
  end

  assign prdata            = r_ff.prdata;
  assign pready            = r_ff.pready;
  assign pslverr           = r_ff.pslverr;
  assign fetch_block       = r_ff.fetch_block;
  assign flash_busy        = r_ff.busy;
  assign flash_erase_pulse = r_ff.erase_p;
  assign flash_write_pulse = r_ff.write_p;
  assign page_select_field = r_ff.page;
  assign word_select_field = r_ff.word;
  assign byte_select       = r_ff.byte_hi;
  assign irq               = r_ff.irq;

endmodule // flash_self_prog

`default_nettype wire

// ### verilog/flash_self_prog_pkg.sv
// Constants, types and the summary of operation for the self-programming block.
// Summary of operation
// - Flash write timing comes from the internal RC oscillator tick, not pclk.
// - Every flash write lasts between 3.7 ms and 4.5 ms.
// - Boot size fuse picks 128/256/512/1024 words; vector and application end follow.
// - Words 0x0000-0x1BFF are the READ_WHILE_WRITE_SECTION section; 0x1C00-0x1FFF the NO_READ_WHILE_WRITE_SECTION section.
// - Program counter and flash word address are 13 bits wide.
// - Pages hold 64 words; six low address bits pick the word.
// - Page erase and write take the page from Z bits 13 down to 7.
// - Z bits 6..1 pick the buffer word; zero during page write.
// - The two top Z bits are ignored in all address decoding.
// - Z bit 0 is zero for store commands; byte select for loads.
// - During page erase or write only the NO_READ_WHILE_WRITE_SECTION section may be read.
// - READ_WHILE_WRITE_SECTION section is unavailable while the busy flag is set.
// - A command counts only if the store executes within four cycles.
// - Busy flag stays set after programming until the re-enable command.
package flash_self_prog_pkg;

  localparam logic [11:0] ctrl_offset     = 12'h000;
  localparam logic [11:0] zptr_offset     = 12'h004;
  localparam logic [11:0] spm_offset      = 12'h008;
  localparam logic [11:0] status_offset   = 12'h00C;
  localparam logic [11:0] mask_offset     = 12'h010;
  localparam logic [11:0] layout_offset   = 12'h014;

  // Command control bit positions.
  localparam int command_enable_pos  = 0;
  localparam int page_erase_pos      = 1;
  localparam int page_write_pos      = 2;
  localparam int lock_write_pos      = 3;
  localparam int rww_reenable_pos    = 4;
  localparam int rww_busy_pos        = 6;

  // Interrupt status bit positions.
  localparam int irq_done_pos        = 0;
  localparam int irq_expire_pos      = 1;
  localparam int irq_block_pos       = 2;

  localparam logic [7:0]  ctrl_reset      = 8'h00;
  localparam logic [2:0]  mask_reset      = 3'h0;

  localparam int pc_width            = 13;
  localparam int word_bits           = 6;
  localparam logic [12:0] no_read_while_write_section_start      = 13'h1C00;
  localparam logic [12:0] flash_last      = 13'h1FFF;

  localparam logic [2:0]  arm_window      = 3'h4;

  // Write time in microseconds and RC oscillator rate in kHz.
  localparam int write_min_us        = 3700;
  localparam int write_max_us        = 4500;
  localparam int rc_khz              = 8000;
  localparam int write_min_ticks     = (write_min_us * rc_khz + 999) / 1000;
  localparam int write_max_ticks     = (write_max_us * rc_khz) / 1000;
  localparam int write_nom_ticks     = (write_min_ticks + write_max_ticks) / 2;

  typedef enum logic [1:0] {op_none, op_erase, op_write, op_lock} op_t;

  typedef struct packed {
    logic [pc_width-1:0] boot_start;
    logic [pc_width-1:0] app_end;
  } boot_layout_t;

  typedef struct packed {
    logic [6:0] page;
    logic [5:0] word;
    logic       byte_hi;
  } zdecode_t;

endpackage

// ### dv/flash_self_prog_props.sv
// Port checker for the flash self-programming block.
`timescale 1ns/10ps
`default_nettype none

module flash_self_prog_props
  import flash_self_prog_pkg::*;
#(
  parameter int write_ticks = 20
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rc_tick,
  input wire logic        fetch_req,
  input wire logic [12:0] fetch_addr,
  input wire logic        fetch_block,
  input wire logic        flash_busy,
  input wire logic        flash_erase_pulse,
  input wire logic        flash_write_pulse,
  input wire logic [6:0]  page_select_field,
  input wire logic [5:0]  word_select_field
);
  // A store strobe accepted at an access edge.
  wire logic spm_wr = psel & penable & pwrite & (paddr == spm_offset);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr seen without pready");
  a_busy_ends_tick: assert property ($fell(flash_busy) |->
    $past(rc_tick) || $past(rc_tick, 2))
    else $error("flash write ended without an oscillator tick");
  a_erase_after_store: assert property (flash_erase_pulse |->
    $past(spm_wr) || $past(spm_wr, 2))
    else $error("erase started without a store strobe");
  a_pulse_then_busy: assert property (
    flash_erase_pulse || flash_write_pulse |=>
    flash_busy && !flash_erase_pulse && !flash_write_pulse)
    else $error("start pulse not single or not followed by busy");
  a_block_rww_only: assert property (fetch_block |->
    $past(fetch_req) && ($past(fetch_addr) < no_read_while_write_section_start))
    else $error("fetch blocked outside the rww section");
  a_no_read_while_write_section_free: assert property (
    fetch_req && (fetch_addr >= no_read_while_write_section_start) |=> !fetch_block)
    else $error("fetch of the no_read_while_write_section section was blocked");
  a_page_latch: assert property ($changed(page_select_field) |->
    $past(spm_wr) || $past(spm_wr, 2))
    else $error("page field moved without a store strobe");
  a_word_latch: assert property ($changed(word_select_field) |->
    $past(spm_wr) || $past(spm_wr, 2))
    else $error("word field moved without a store strobe");

  // Main scenarios reached by the bench.
  c_erase: cover property (flash_erase_pulse);
  c_write: cover property (flash_write_pulse);
  c_block: cover property (fetch_block);
  c_slverr: cover property (pslverr);
endmodule // flash_self_prog_props

bind flash_self_prog flash_self_prog_props
  #(.write_ticks(write_ticks)) flash_self_prog_props_inst (.*);

`default_nettype wire

// ### dv/boot_core_model.sv
// Core side model: free running RC ticks and instruction fetches.
`timescale 1ns/10ps
`default_nettype none

module boot_core_model
(
  input  wire logic        pclk,
  output logic             rc_tick,
  output logic             fetch_req,
  output logic [12:0]      fetch_addr
);
  logic [4:0] div_ff;

  initial
  begin
    rc_tick = 1'b0;
    fetch_req = 1'b0;
    fetch_addr = 13'h0000;
    div_ff = 5'h00;
  end

  // The oscillator runs free, one tick every 31 clock cycles.
  always @(posedge pclk)
  begin
    div_ff <= (div_ff == 5'h1E) ? 5'h00 : div_ff + 5'h01;
    rc_tick <= (div_ff == 5'h1E);
  end

  // One fetch; afterwards the address is inverted so no stale value shows.
  task automatic fetch(input logic [12:0] a);
    @(posedge pclk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_req <= 1'b0;
    fetch_addr <= ~a;
  endtask
endmodule // boot_core_model

`default_nettype wire

// ### dv/flash_self_prog_tb.sv
// Self-checking bench for the flash self-programming block.
`timescale 1ns/10ps
`default_nettype none

module flash_self_prog_tb;
  import flash_self_prog_pkg::*;
  localparam int wt = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        errv, rc_tick, eeprom_write_active, fetch_req, fetch_block;
  logic [1:0]  boot_size_fuse;
  logic [12:0] fetch_addr;
  logic        flash_busy, flash_erase_pulse, flash_write_pulse;
  logic [6:0]  page_select_field;
  logic [5:0]  word_select_field;
  logic        byte_select, irq;
  int          n_errors, total_checks, ticks;

  flash_self_prog #(.write_ticks(wt)) flash_self_prog_inst (.*);
  boot_core_model boot_core_model_inst (.*);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Oscillator ticks seen while a flash write runs.
  always @(posedge pclk) if (flash_busy === 1'b1 && rc_tick) ticks++;

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 20);
    // A slave that never answers counts as a mismatch.
    if (pready !== 1'b1)
      n_errors++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [31:0] c, input logic [15:0] z);
    do apb(1'b0, ctrl_offset, 32'h0); while (rdv[0] !== 1'b0);
    while (eeprom_write_active !== 1'b0) @(posedge pclk);
    apb(1'b1, zptr_offset, {16'h0000, z});
    apb(1'b1, ctrl_offset, c);
    apb(1'b1, spm_offset, 32'h0);
    @(posedge pclk);
  endtask

  task automatic t_regs();
    logic [12:0] bs;
    apb(1'b0, ctrl_offset, 32'h0);
    chk("ctrl reset", rdv, {24'h000000, ctrl_reset});
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", errv, 32'h1);
    chk("unmapped data", rdv, 32'h0);
    for (int f = 0; f < 4; f++)
    begin
      boot_size_fuse <= f[1:0];
      bs = 13'h0000 - (13'h0080 << (3 - f));
      apb(1'b0, layout_offset, 32'h0);
      chk("layout", rdv, {3'h0, bs - 13'h0001, 3'h0, bs});
    end
  endtask

  task automatic t_fill(input logic [15:0] z);
    cmd(32'h01, z);
    chk("word", word_select_field, z[6:1]);
    chk("byte", byte_select, z[0]);
    chk("page", page_select_field, z[13:7]);
  endtask

  task automatic t_erase();
    apb(1'b1, mask_offset, 32'h1);
    ticks = 0;
    cmd(32'h03, 16'hEA80);
    chk("erase pulse", flash_erase_pulse, 32'h1);
    chk("erase page", page_select_field, 7'h55);
    boot_core_model_inst.fetch(13'h1BFF);
    @(posedge pclk);
    chk("rww fetch", fetch_block, 32'h1);
    boot_core_model_inst.fetch(13'h1C00);
    @(posedge pclk);
    chk("no_read_while_write_section fetch", fetch_block, 32'h0);
    while (flash_busy !== 1'b0) @(posedge pclk);
    chk("ticks", ticks >= wt - 1 && ticks <= wt + 1, 32'h1);
    apb(1'b0, ctrl_offset, 32'h0);
    chk("ctrl done", rdv, 32'h40);
    boot_core_model_inst.fetch(13'h0000);
    @(posedge pclk);
    chk("rww still busy", fetch_block, 32'h1);
    chk("irq set", irq, 32'h1);
    apb(1'b1, status_offset, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq clear", irq, 32'h0);
    cmd(32'h11, 16'h0000);
    do apb(1'b0, ctrl_offset, 32'h0); while (rdv[0] !== 1'b0);
    chk("rww busy", rdv[rww_busy_pos], 32'h0);
    boot_core_model_inst.fetch(13'h0000);
    @(posedge pclk);
    chk("rww free", fetch_block, 32'h0);
  endtask

  // A store past the arming window is dropped; a prompt one starts a write.
  task automatic t_window();
    apb(1'b1, ctrl_offset, 32'h05);
    repeat (6) @(posedge pclk);
    apb(1'b1, spm_offset, 32'h0);
    @(posedge pclk);
    chk("late store", flash_write_pulse, 32'h0);
    apb(1'b0, status_offset, 32'h0);
    chk("expired", rdv[irq_expire_pos], 32'h1);
    cmd(32'h05, 16'h0100);
    chk("write pulse", flash_write_pulse, 32'h1);
    while (flash_busy !== 1'b0) @(posedge pclk);
    cmd(32'h11, 16'h0000);
    // Lock write is timed like the others but keeps the READ_WHILE_WRITE_SECTION section free.
    cmd(32'h09, 16'h0001);
    chk("lock busy", flash_busy, 32'h1);
    boot_core_model_inst.fetch(13'h0000);
    @(posedge pclk);
    chk("lock fetch", fetch_block, 32'h0);
    while (flash_busy !== 1'b0) @(posedge pclk);
    apb(1'b0, ctrl_offset, 32'h0);
    chk("lock done", rdv, 32'h00);
  endtask

  task automatic t_refuse();
    apb(1'b1, status_offset, 32'h7);
    eeprom_write_active <= 1'b1;
    apb(1'b1, ctrl_offset, 32'h03);
    apb(1'b0, ctrl_offset, 32'h0);
    chk("refused ctrl", rdv[3:0], 32'h0);
    apb(1'b0, status_offset, 32'h0);
    chk("refused flag", rdv[irq_block_pos], 32'h1);
    eeprom_write_active <= 1'b0;
  endtask

  initial
  begin
    n_errors = 0;
    total_checks = 0;
    ticks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    boot_size_fuse = 2'h0;
    eeprom_write_active = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fill(16'h004A);
    t_fill(16'h007F);
    t_erase();
    t_window();
    t_refuse();
    tally_and_finish();
  end

  // Cuts a hang short well past the expected run length.
  initial
  begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule // flash_self_prog_tb

`default_nettype wire
